/* File: common/hbpwm_pkg.sv */
// Package: timing constants, phases and output carrier for the half-bridge PWM sequencer
package hbpwm_pkg;

  // Logic clock period
  localparam int unsigned CLK_PERIOD_PS     = 4000;

  // Oscillator period in logic cycles (250 MHz / 625 = 400 kHz)
  localparam int unsigned OSC_PERIOD_CYC    = 625;

  // Main clock pulse width, 65 ns, rounded up to whole cycles
  localparam int unsigned CLK_PULSE_PS      = 65000;
  localparam int unsigned CLK_PULSE_CYC     =
    (CLK_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Delay slope: 2 pF per ohm; setting is resistance in ohms
  localparam int unsigned DELAY_PF          = 2;

  // Primary delay offset 20 ns, minimum programmable delay 30 ns
  localparam int unsigned PRI_DELAY_OFS_PS  = 20000;
  localparam int unsigned PRI_DELAY_MIN_PS  = 30000;
  localparam int unsigned PRI_DELAY_MIN_CYC =
    (PRI_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Rectifier delay offset 30 ns
  localparam int unsigned REC_DELAY_OFS_PS  = 30000;

  // Width of resistor setting and of delay counters
  localparam int unsigned RSET_W            = 16;
  localparam int unsigned CNT_W             = 16;

  // Phase sequence of the converter
  typedef enum logic [1:0] {
    HBPWM_LOW_XFER,
    HBPWM_FREE_A,
    HBPWM_HIGH_XFER,
    HBPWM_FREE_B
  } hbpwm_phase_e;

  // Four drive outputs travel together
  typedef struct packed {
    logic low_side_gate_out;
    logic high_side_gate_out;
    logic rectifier_drive_a;
    logic rectifier_drive_b;
  } hbpwm_drive_s;

  localparam hbpwm_drive_s DRIVE_OFF = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : hbpwm_pkg

/* File: src/hbpwm_delay_calc.sv */
// Converts a resistor setting to a delay count in logic clock cycles
`timescale 1ns/100ps
module hbpwm_delay_calc
  import hbpwm_pkg::*;
#(
  parameter int unsigned OFS_PS = 20000,
  parameter int unsigned MIN_PS = 0
)
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [RSET_W-1:0] rset,
  output logic      [CNT_W-1:0]  cycles
);

  logic [CNT_W-1:0] cycles_nxt;
  logic [31:0]      ps_c;
  logic [31:0]      cyc_c;

  // Ohms * 2 pF gives ps; least time rounds up
  always_comb
  begin
    ps_c = 32'(rset) * 32'(DELAY_PF) + 32'(OFS_PS);
    if (ps_c < 32'(MIN_PS))
    begin
      ps_c = 32'(MIN_PS);
    end
    cyc_c = (ps_c + 32'(CLK_PERIOD_PS) - 32'd1) / 32'(CLK_PERIOD_PS);
    if (cyc_c > 32'h0000_FFFF)
    begin
      cycles_nxt = 16'hFFFF;
    end
    else if (cyc_c == 32'h0000_0000)
    begin
      cycles_nxt = 16'h0001;
    end
    else
    begin
      cycles_nxt = cyc_c[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cycles <= 16'h0001;
    end
    else
    begin
      cycles <= cycles_nxt;
    end
  end

endmodule : hbpwm_delay_calc

/* File: src/hbpwm_sequencer.sv */
// Half-bridge PWM sequencer: primary gates and rectifier drives with dead-times
`timescale 1ns/100ps
//
// Functional notes
// - Phases: low xfer, free, high xfer, free
// - Delayed clock lags main by setting*2pF+20ns
// - Main clock rise turns off one rectifier drive if no primary is on
// - Delayed clock fall turns due primary on
// - Main clock pulse is 65 ns rounded up to 17 cycles
// - Primary delay never below 30 ns
// - Pulse ends on ramp trip or delayed rise
// - Rectifier on after setting*2pF+30ns dead-time
// - Low side on: drive b on, a off
// - Freewheel: primaries off, both rectifiers on
// - Drive b off no later than high side on
// - After high side, dead-time, both rectifiers on
// - Max duty set by delayed clock rise
// - Oscillator alternates sides every cycle
// - Clock pulse forces gap between primaries
// - Ramp reset on trip, limit, or cycle end
module hbpwm_sequencer
  import hbpwm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              enable,
  input  wire logic              ramp_above_ctrl,
  input  wire logic              current_limit,
  input  wire logic [RSET_W-1:0] primary_delay_set,
  input  wire logic [RSET_W-1:0] rectifier_delay_set,
  output hbpwm_drive_s           drive,
  output logic                   main_clk_out,
  output logic                   delayed_clk_out,
  output logic                   ramp_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Delay counts

  logic [CNT_W-1:0] pri_delay_cyc;
  logic [CNT_W-1:0] rec_delay_cyc;

  hbpwm_delay_calc #(
    .OFS_PS (PRI_DELAY_OFS_PS),
    .MIN_PS (PRI_DELAY_MIN_PS)
  ) u_pri_delay (
    .clk    (clk),
    .srst   (srst),
    .rset   (primary_delay_set),
    .cycles (pri_delay_cyc)
  );

  hbpwm_delay_calc #(
    .OFS_PS (REC_DELAY_OFS_PS),
    .MIN_PS (0)
  ) u_rec_delay (
    .clk    (clk),
    .srst   (srst),
    .rset   (rectifier_delay_set),
    .cycles (rec_delay_cyc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser

  logic cmp_meta_r;
  logic cmp_sync_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end
    else
    begin
      cmp_meta_r <= ramp_above_ctrl;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator, main clock and delayed clock

  logic [15:0] osc_cnt_r;
  logic [15:0] osc_cnt_nxt;
  logic        osc_wrap;
  logic        main_rise;
  logic [15:0] dly_rise_pt;
  logic [15:0] dly_fall_pt;
  logic        dly_rise;
  logic        dly_fall;
  logic        main_clk_nxt;
  logic        dly_clk_nxt;

  always_comb
  begin
    osc_wrap    = (osc_cnt_r == 16'(OSC_PERIOD_CYC - 1));
    // Idle parks on the last count so the first main pulse is full width
    if (!enable)
    begin
      osc_cnt_nxt = 16'(OSC_PERIOD_CYC - 1);
    end
    else if (osc_wrap)
    begin
      osc_cnt_nxt = 16'h0000;
    end
    else
    begin
      osc_cnt_nxt = osc_cnt_r + 16'h0001;
    end
    main_rise   = (osc_cnt_r == 16'h0000);
    // Delay clamped inside one period; a huge setting saturates, not wraps
    dly_rise_pt = (pri_delay_cyc > 16'(OSC_PERIOD_CYC - CLK_PULSE_CYC - 1))
                ? 16'(OSC_PERIOD_CYC - CLK_PULSE_CYC - 1) : pri_delay_cyc;
    dly_fall_pt = dly_rise_pt + 16'(CLK_PULSE_CYC);
    dly_rise    = (osc_cnt_r == dly_rise_pt);
    dly_fall    = (osc_cnt_r == dly_fall_pt);
    main_clk_nxt = (osc_cnt_nxt < 16'(CLK_PULSE_CYC));
    dly_clk_nxt  = (osc_cnt_nxt >= dly_rise_pt) && (osc_cnt_nxt < dly_fall_pt);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      osc_cnt_r       <= 16'(OSC_PERIOD_CYC - 1);
      main_clk_out    <= 1'b0;
      delayed_clk_out <= 1'b0;
    end
    else
    begin
      osc_cnt_r       <= osc_cnt_nxt;
      main_clk_out    <= main_clk_nxt;
      delayed_clk_out <= dly_clk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase and drive sequencing

  hbpwm_phase_e     phase_r;
  hbpwm_phase_e     phase_nxt;
  logic             side_high_r;
  logic             side_high_nxt;
  logic             pri_on_r;
  logic             pri_on_nxt;
  logic [CNT_W-1:0] dt2_cnt_r;
  logic [CNT_W-1:0] dt2_cnt_nxt;
  logic             dt2_run_r;
  logic             dt2_run_nxt;
  hbpwm_drive_s     drive_nxt;
  logic             pri_end;
  logic             ramp_reset_nxt;

  always_comb
  begin
    phase_nxt      = phase_r;
    side_high_nxt  = side_high_r;
    pri_on_nxt     = pri_on_r;
    dt2_cnt_nxt    = dt2_cnt_r;
    dt2_run_nxt    = dt2_run_r;
    drive_nxt      = drive;
    pri_end        = pri_on_r && (cmp_sync_r || dly_rise);
    ramp_reset_nxt = cmp_sync_r || current_limit || osc_wrap;

    if (main_rise)
    begin
      // Each oscillator cycle serves the other side
      side_high_nxt = ~side_high_r;
      // Rectifier under a still-live primary stays on; it drops with the next turn-on
      drive_nxt.rectifier_drive_a = (side_high_r && !pri_on_r) ? 1'b0
                                  : drive.rectifier_drive_a;
      drive_nxt.rectifier_drive_b = (side_high_r || pri_on_r) ? drive.rectifier_drive_b
                                  : 1'b0;
      dt2_run_nxt = 1'b0;
    end

    if (dly_fall && !pri_on_r)
    begin
      pri_on_nxt  = 1'b1;
      // A late dead-time must not re-enable the rectifier opposite this pulse
      dt2_run_nxt = 1'b0;
      // Side flag already toggled at this cycle's main rise
      if (!side_high_r)
      begin
        phase_nxt = HBPWM_LOW_XFER;
        drive_nxt.low_side_gate_out  = 1'b1;
        drive_nxt.rectifier_drive_a  = 1'b0;
        drive_nxt.rectifier_drive_b  = 1'b1;
      end
      else
      begin
        phase_nxt = HBPWM_HIGH_XFER;
        drive_nxt.high_side_gate_out = 1'b1;
        drive_nxt.rectifier_drive_a  = 1'b1;
        drive_nxt.rectifier_drive_b  = 1'b0;
      end
    end
    else if (pri_end)
    begin
      pri_on_nxt = 1'b0;
      drive_nxt.low_side_gate_out  = 1'b0;
      drive_nxt.high_side_gate_out = 1'b0;
      dt2_run_nxt = 1'b1;
      dt2_cnt_nxt = rec_delay_cyc;
      phase_nxt   = (phase_r == HBPWM_LOW_XFER) ? HBPWM_FREE_A : HBPWM_FREE_B;
    end
    else if (dt2_run_r && !main_rise)
    begin
      if (dt2_cnt_r <= 16'h0001)
      begin
        dt2_run_nxt = 1'b0;
        drive_nxt.rectifier_drive_a = 1'b1;
        drive_nxt.rectifier_drive_b = 1'b1;
      end
      else
      begin
        dt2_cnt_nxt = dt2_cnt_r - 16'h0001;
      end
    end

    if (!enable)
    begin
      drive_nxt      = DRIVE_OFF;
      pri_on_nxt     = 1'b0;
      dt2_run_nxt    = 1'b0;
      ramp_reset_nxt = 1'b1;
      phase_nxt      = HBPWM_FREE_B;
      side_high_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_r         <= HBPWM_FREE_B;
      side_high_r     <= 1'b1;
      pri_on_r        <= 1'b0;
      dt2_cnt_r       <= 16'h0000;
      dt2_run_r       <= 1'b0;
      drive           <= DRIVE_OFF;
      ramp_reset      <= 1'b1;
    end
    else
    begin
      phase_r         <= phase_nxt;
      side_high_r     <= side_high_nxt;
      pri_on_r        <= pri_on_nxt;
      dt2_cnt_r       <= dt2_cnt_nxt;
      dt2_run_r       <= dt2_run_nxt;
      drive           <= drive_nxt;
      ramp_reset      <= ramp_reset_nxt;
    end
  end

endmodule : hbpwm_sequencer

/* File: tb/hbpwm_chk.sv */
// Checker: port assertions for the half-bridge PWM sequencer
`timescale 1ns/100ps
module hbpwm_chk
  import hbpwm_pkg::*;
(
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         enable,
  input wire logic         ramp_above_ctrl,
  input wire logic         current_limit,
  input wire hbpwm_drive_s drive,
  input wire logic         main_clk_out,
  input wire logic         delayed_clk_out,
  input wire logic         ramp_reset
);
  logic lo;
  logic hi;
  logic ra;
  logic rb;
  assign lo = drive.low_side_gate_out;
  assign hi = drive.high_side_gate_out;
  assign ra = drive.rectifier_drive_a;
  assign rb = drive.rectifier_drive_b;
  default clocking cb @(posedge clk); endclocking
  ////////////////////////////////////////////////////////////////////////////
  sequence s_pulse;
    ##16 main_clk_out ##1 !main_clk_out;
  endsequence
  property p_rst;
    srst |=> drive == DRIVE_OFF && ramp_reset;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
  property p_dis;
    disable iff (srst) !enable |=> drive == DRIVE_OFF;
  endproperty
  a_dis: assert property (p_dis) else $error("outputs live while disabled");
  property p_gap;
    disable iff (srst) !(lo && hi);
  endproperty
  a_gap: assert property (p_gap) else $error("both primaries on");
  property p_low;
    disable iff (srst) lo |-> rb && !ra;
  endproperty
  a_low: assert property (p_low) else $error("bad rectifiers in low phase");
  property p_high;
    disable iff (srst) hi |-> ra && !rb;
  endproperty
  a_high: assert property (p_high) else $error("bad rectifiers in high phase");
  property p_clk;
    disable iff (srst || !enable) $rose(main_clk_out) |-> s_pulse;
  endproperty
  a_clk: assert property (p_clk) else $error("main pulse width wrong");
  property p_srof;
    disable iff (srst || !enable) $rose(main_clk_out) |-> ##[0:2] !(ra && rb);
  endproperty
  a_srof: assert property (p_srof) else $error("rectifier kept on");
  property p_on;
    disable iff (srst || !enable) $fell(delayed_clk_out) |-> ##[0:2] (lo || hi);
  endproperty
  a_on: assert property (p_on) else $error("primary not started");
  property p_end;
    disable iff (srst || !enable) $rose(delayed_clk_out) |-> ##[0:2] !(lo || hi);
  endproperty
  a_end: assert property (p_end) else $error("primary not ended");
  property p_dt;
    disable iff (srst || !enable) $fell(lo) |-> !ra [*8];
  endproperty
  a_dt: assert property (p_dt) else $error("rectifier dead-time short");
  property p_trip;
    disable iff (srst || !enable) ramp_above_ctrl && (lo || hi) |-> ##[1:4] !(lo || hi);
  endproperty
  a_trip: assert property (p_trip) else $error("trip ignored");
  property p_lim;
    disable iff (srst) current_limit |-> ##[0:2] ramp_reset;
  endproperty
  a_lim: assert property (p_lim) else $error("ramp not reset");
endmodule : hbpwm_chk

bind hbpwm_sequencer hbpwm_chk hbpwm_chk_inst (.clk(clk), .srst(srst), .enable(enable),
  .ramp_above_ctrl(ramp_above_ctrl), .current_limit(current_limit), .drive(drive),
  .main_clk_out(main_clk_out), .delayed_clk_out(delayed_clk_out), .ramp_reset(ramp_reset));

/* File: tb/hbpwm_far_side.sv */
// Far side: ramp comparator and rectifier-against-primary conflict monitor
`timescale 1ns/100ps
module hbpwm_far_side
  import hbpwm_pkg::*;
(
  input  wire logic         clk,
  input  wire hbpwm_drive_s drive,
  input  wire logic         ramp_reset,
  input  wire logic [15:0]  ctrl_level,
  output logic              ramp_above_ctrl = 1'b0,
  output int                fault_cnt = 0
);
  logic [15:0] ramp_r = 16'h0000;
  always @(posedge clk)
  begin
    ramp_r <= ramp_reset ? 16'h0000 : ramp_r + 16'h0001;
    ramp_above_ctrl <= ramp_r > ctrl_level;
    // Conducting rectifier against a live primary shorts the winding
    if ((drive.low_side_gate_out && drive.rectifier_drive_a) ||
        (drive.high_side_gate_out && drive.rectifier_drive_b))
      fault_cnt <= fault_cnt + 1;
  end
endmodule : hbpwm_far_side

/* File: tb/hbpwm_sequencer_tb_top.sv */
// Testbench top for the half-bridge PWM sequencer
`timescale 1ns/100ps
module hbpwm_sequencer_tb_top
  import hbpwm_pkg::*;
;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         enable = 1'b1;
  logic         cur_lim = 1'b0;
  logic [15:0]  pset = 16'h1388;
  logic [15:0]  rset = 16'h1388;
  logic [15:0]  ctrl = 16'hffff;
  logic         ramp_above;
  hbpwm_drive_s drive;
  logic         mck;
  logic         dck;
  logic         rr;
  int           fault;
  int           error_cnt = 0;
  int           checks_done = 0;
  hbpwm_sequencer hbpwm_sequencer_inst (.clk(clk), .srst(srst), .enable(enable),
    .ramp_above_ctrl(ramp_above), .current_limit(cur_lim), .primary_delay_set(pset),
    .rectifier_delay_set(rset), .drive(drive), .main_clk_out(mck),
    .delayed_clk_out(dck), .ramp_reset(rr));
  hbpwm_far_side hbpwm_far_side_inst (.clk(clk), .drive(drive), .ramp_reset(rr),
    .ctrl_level(ctrl), .ramp_above_ctrl(ramp_above), .fault_cnt(fault));
  initial
  begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  function automatic logic sig(input int s);
    case (s)
      0: return drive.low_side_gate_out;
      1: return drive.high_side_gate_out;
      2: return drive.rectifier_drive_a;
      3: return drive.rectifier_drive_b;
      4: return mck;
      5: return dck;
      default: return drive.low_side_gate_out | drive.high_side_gate_out;
    endcase
  endfunction : sig
  // Bounded wait; cycles counted from the call
  task automatic wait_for(input int s, input logic v, output int n);
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (sig(s) !== v && n < 2000);
    if (sig(s) !== v)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask : wait_for
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_seq;
    int w;
    int n;
    int m;
    wait_for(0, 1'b1, n);
    check(drive, 4'b1001);
    wait_for(0, 1'b0, w);
    check(w, OSC_PERIOD_CYC - CLK_PULSE_CYC);
    wait_for(2, 1'b1, n);
    check(n >= 10 && n <= 12, 1'b1);
    check(drive, 4'b0011);
    wait_for(1, 1'b1, m);
    check(drive, 4'b0110);
    check(w + n + m, OSC_PERIOD_CYC);
    wait_for(3, 1'b1, n);
    check(drive, 4'b0011);
    wait_for(6, 1'b1, m);
    check(drive.low_side_gate_out, 1'b1);
    $display("t_seq done");
  endtask : t_seq
  task automatic t_delay;
    logic [15:0] ohm [3] = '{16'h0000, 16'h1388, 16'h4e20};
    int          d [3] = '{8, 8, 15};
    int          n;
    int          m;
    for (int i = 0; i < 3; i++)
    begin
      pset = ohm[i];
      tick(700);
      wait_for(4, 1'b1, n);
      wait_for(5, 1'b1, n);
      check(n, d[i]);
      wait_for(4, 1'b0, m);
      check(n + m, CLK_PULSE_CYC);
    end
    $display("t_delay done");
  endtask : t_delay
  task automatic t_trip;
    int w;
    ctrl = 16'h00c8;
    wait_for(0, 1'b1, w);
    wait_for(0, 1'b0, w);
    check(w < OSC_PERIOD_CYC - CLK_PULSE_CYC - 1, 1'b1);
    // Let the trip drain so only the limit can raise the ramp reset
    ctrl = 16'hffff;
    tick(20);
    check(rr, 1'b0);
    cur_lim = 1'b1;
    tick(1);
    check(rr, 1'b1);
    cur_lim = 1'b0;
    tick(1);
    check(rr, 1'b0);
    $display("t_trip done");
  endtask : t_trip
  task automatic t_disable;
    int n;
    wait_for(1, 1'b1, n);
    tick(5);
    enable = 1'b0;
    tick(1);
    check(drive, DRIVE_OFF);
    tick(700);
    check(drive, DRIVE_OFF);
    enable = 1'b1;
    wait_for(6, 1'b1, n);
    check(drive.low_side_gate_out, 1'b1);
    check(fault, 0);
    $display("t_disable done");
  endtask : t_disable
  initial
  begin
    tick(6);
    check(drive, DRIVE_OFF);
    check(rr, 1'b1);
    srst = 1'b0;
    t_seq();
    t_delay();
    t_trip();
    t_disable();
    wrap_up();
  end
endmodule : hbpwm_sequencer_tb_top
